// ==== shared/psrc_pkg.sv ====
// Package: register map, field layout and reset values of the reset control
package psrc_pkg;

   localparam logic [11:0] SRC2_OFFSET   = 12'h048;
   localparam logic [31:0] SRC2_RESET    = 32'h00000000;
   // Writable bits: phy (30), mac (28), io ports g..a (6:0)
   localparam logic [31:0] SRC2_RW_MASK  = 32'h5000007F;
   localparam int          PHY_BIT       = 30;
   localparam int          MAC_BIT       = 28;
   localparam int          PORT_LSB      = 0;
   localparam int          PORT_COUNT    = 7;
   localparam logic [31:0] RDATA_IDLE    = 32'h00000000;

   // APB slave phases
   typedef enum logic [1:0] {
      PSRC_IDLE,
      PSRC_ACCESS,
      PSRC_DONE
   } psrc_state_t;

endpackage : psrc_pkg

// ==== logic/psrc_apb_if.sv ====
// APB slave front end: one-wait-state answer with decode of the single word
`timescale 1ns/10ps
`default_nettype none

module psrc_apb_if
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   output var  logic        pready_q,
   output var  logic        pslverr_q,
   output var  logic        wr_hit_q,
   output var  logic        rd_hit_q
);

   psrc_pkg::psrc_state_t state_q;
   logic                  hit;

   // Word decode; anything else answers with an error
   assign hit = (paddr == psrc_pkg::SRC2_OFFSET);

   // Phase tracking: ready comes one cycle into the access phase
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         state_q   <= psrc_pkg::PSRC_IDLE;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         wr_hit_q  <= 1'b0;
         rd_hit_q  <= 1'b0;
      end
      else
      begin
         wr_hit_q <= 1'b0;
         rd_hit_q <= 1'b0;
         unique case (state_q)
            psrc_pkg::PSRC_IDLE:
            begin
               pready_q  <= 1'b0;
               pslverr_q <= 1'b0;
               if (psel && penable)
               begin
                  state_q   <= psrc_pkg::PSRC_DONE;
                  pready_q  <= 1'b1;
                  pslverr_q <= !hit;
                  wr_hit_q  <= hit && pwrite;
                  rd_hit_q  <= hit && !pwrite;
               end
            end
            psrc_pkg::PSRC_ACCESS:
               state_q <= psrc_pkg::PSRC_IDLE;
            psrc_pkg::PSRC_DONE:
            begin
               // Ready drops after the completing edge
               state_q   <= psrc_pkg::PSRC_IDLE;
               pready_q  <= 1'b0;
               pslverr_q <= 1'b0;
            end
         endcase
      end
   end

endmodule // psrc_apb_if

`default_nettype wire

// ==== logic/psrc_top.sv ====
// Software reset control register with capability-masked writes
`timescale 1ns/10ps
`default_nettype none

module psrc_top
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [31:0] capability_mask_four,
   output var  logic [31:0] prdata_q,
   output var  logic        pready,
   output var  logic        pslverr,
   output var  logic        phy_unit_reset_q,
   output var  logic        mac_unit_reset_q,
   output var  logic [6:0]  io_port_reset_q
);

   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic        wr_hit;
   logic        rd_hit;
   logic        pready_q;
   logic        pslverr_q;

   ////////////////////////////////////////////////////////////////////////
   // Bus front end
   psrc_apb_if u_apb
   (
      .clk       (clk),
      .rstn      (rstn),
      .psel      (psel),
      .penable   (penable),
      .pwrite    (pwrite),
      .paddr     (paddr),
      .pready_q  (pready_q),
      .pslverr_q (pslverr_q),
      .wr_hit_q  (wr_hit),
      .rd_hit_q  (rd_hit)
   );
   assign pready  = pready_q;
   assign pslverr = pslverr_q;

   // Write data sampled during access; held stable by the master
   logic [31:0] wdata_q;
   always_ff @(posedge clk)
   begin
      if (!rstn)
         wdata_q <= psrc_pkg::SRC2_RESET;
      else if (psel && penable && !pready_q)
         wdata_q <= pwdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Masked update: only present, writable bits change
   function automatic logic [31:0] masked_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [31:0] en
   );
      logic [31:0] m;
      m = en & psrc_pkg::SRC2_RW_MASK;
      masked_merge = (old_v & ~m) | (new_v & m);
   endfunction

   // Next value of the control word
   always_comb
   begin
      ctrl_d = ctrl_q;
      if (wr_hit)
         ctrl_d = masked_merge(ctrl_q, wdata_q,
                               capability_mask_four);
   end

   // Control word; cleared so no unit is forced into reset
   always_ff @(posedge clk)
   begin
      if (!rstn)
         ctrl_q <= psrc_pkg::SRC2_RESET;
      else
         ctrl_q <= ctrl_d;
   end

   ////////////////////////////////////////////////////////////////////////
   // Reset outputs; registered from next value so they track the word
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         phy_unit_reset_q <= 1'b0;
         mac_unit_reset_q <= 1'b0;
         io_port_reset_q  <= '0;
      end
      else
      begin
         phy_unit_reset_q <= ctrl_d[psrc_pkg::PHY_BIT];
         mac_unit_reset_q <= ctrl_d[psrc_pkg::MAC_BIT];
         io_port_reset_q  <= ctrl_d[psrc_pkg::PORT_LSB +:
                                    psrc_pkg::PORT_COUNT];
      end
   end

   // Word decode shared by the read path and the refusal check
   function automatic logic is_ctrl_word(input logic [11:0] a);
      is_ctrl_word = (a == psrc_pkg::SRC2_OFFSET);
   endfunction

   // Read data: word on a hit, zero otherwise; reserved bits are zero.
   // Cleared at the completing edge so the bus never shows stale data.
   always_ff @(posedge clk)
   begin
      if (!rstn)
         prdata_q <= psrc_pkg::RDATA_IDLE;
      else if (psel && penable && !pready_q && !pwrite &&
               is_ctrl_word(paddr))
         prdata_q <= ctrl_q & psrc_pkg::SRC2_RW_MASK;
      else
         prdata_q <= psrc_pkg::RDATA_IDLE;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   // Synchronous reset: the word is zero one edge after rstn is seen low
   property p_reset_zero;
      @(posedge clk)
      !rstn |=> ctrl_q == psrc_pkg::SRC2_RESET;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("control word not cleared by reset");

   property p_mask_gate;
      @(posedge clk) disable iff (!rstn)
      wr_hit |=> ((ctrl_q ^ $past(ctrl_q)) &
                  ~$past(capability_mask_four)) == 32'h00000000;
   endproperty
   a_mask_gate: assert property (p_mask_gate)
      else $error("absent unit bit changed");

   property p_reserved_zero;
      @(posedge clk) disable iff (!rstn)
      (ctrl_q & ~psrc_pkg::SRC2_RW_MASK) == 32'h00000000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bit set");

   property p_phy;
      @(posedge clk) disable iff (!rstn)
      phy_unit_reset_q == ctrl_q[psrc_pkg::PHY_BIT];
   endproperty
   a_phy: assert property (p_phy)
      else $error("phy reset does not follow its bit");

   property p_mac;
      @(posedge clk) disable iff (!rstn)
      mac_unit_reset_q == ctrl_q[psrc_pkg::MAC_BIT];
   endproperty
   a_mac: assert property (p_mac)
      else $error("mac reset does not follow its bit");

   property p_ports;
      @(posedge clk) disable iff (!rstn)
      io_port_reset_q == ctrl_q[psrc_pkg::PORT_LSB +: psrc_pkg::PORT_COUNT];
   endproperty
   a_ports: assert property (p_ports)
      else $error("port resets do not follow their bits");

   property p_hold;
      @(posedge clk) disable iff (!rstn)
      !wr_hit |=> $stable(ctrl_q) && $stable(io_port_reset_q);
   endproperty
   a_hold: assert property (p_hold)
      else $error("reset changed without a write");

   property p_write_value;
      @(posedge clk) disable iff (!rstn)
      wr_hit && (capability_mask_four == 32'hFFFFFFFF) |=>
         ctrl_q == ($past(wdata_q) & psrc_pkg::SRC2_RW_MASK);
   endproperty
   a_write_value: assert property (p_write_value)
      else $error("write with full mask not stored");

   property p_ready_one;
      @(posedge clk) disable iff (!rstn)
      pready_q |=> !pready_q;
   endproperty
   a_ready_one: assert property (p_ready_one)
      else $error("ready held longer than one cycle");

   ////////////////////////////////////////////////////////////////////////
   // Checks on the reset outputs and the bus answer
   // Slices of the mask and staged data for the port checks
   logic [psrc_pkg::PORT_COUNT-1:0] port_mask;
   logic [psrc_pkg::PORT_COUNT-1:0] port_wdata;
   assign port_mask  = capability_mask_four[psrc_pkg::PORT_LSB +:
                                            psrc_pkg::PORT_COUNT];
   assign port_wdata = wdata_q[psrc_pkg::PORT_LSB +: psrc_pkg::PORT_COUNT];

   // Every unit leaves reset with the word, and the bus goes quiet
   property p_reset_outputs;
      @(posedge clk)
      !rstn |=> !phy_unit_reset_q && !mac_unit_reset_q &&
                io_port_reset_q == 7'h00 && !pready_q && !pslverr_q;
   endproperty
   a_reset_outputs: assert property (p_reset_outputs)
      else $error("unit reset left on by system reset");

   // A present phy bit takes the written value at the commit edge
   property p_set_phy;
      @(posedge clk) disable iff (!rstn)
      wr_hit && capability_mask_four[psrc_pkg::PHY_BIT] |=>
         phy_unit_reset_q == $past(wdata_q[psrc_pkg::PHY_BIT]);
   endproperty
   a_set_phy: assert property (p_set_phy)
      else $error("phy reset did not take the written bit");

   // A present mac bit takes the written value at the commit edge
   property p_set_mac;
      @(posedge clk) disable iff (!rstn)
      wr_hit && capability_mask_four[psrc_pkg::MAC_BIT] |=>
         mac_unit_reset_q == $past(wdata_q[psrc_pkg::MAC_BIT]);
   endproperty
   a_set_mac: assert property (p_set_mac)
      else $error("mac reset did not take the written bit");

   // Ports: enabled bits take the data, the others keep their state
   property p_port_update;
      @(posedge clk) disable iff (!rstn)
      wr_hit |=> io_port_reset_q ==
         (($past(port_wdata) & $past(port_mask)) |
          ($past(io_port_reset_q) & ~$past(port_mask)));
   endproperty
   a_port_update: assert property (p_port_update)
      else $error("port resets did not take the masked write");

   // A unit stays in reset until software clears its bit
   property p_unit_held;
      @(posedge clk) disable iff (!rstn)
      !wr_hit |=> $stable(phy_unit_reset_q) && $stable(mac_unit_reset_q);
   endproperty
   a_unit_held: assert property (p_unit_held)
      else $error("phy or mac reset changed without a write");

   // Read answer carries the word while ready stands
   property p_read_data;
      @(posedge clk) disable iff (!rstn)
      rd_hit |-> pready_q && !pslverr_q && prdata_q == ctrl_q;
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("read answer does not match the word");

   // Read data is zero whenever no answer stands
   property p_rdata_idle;
      @(posedge clk) disable iff (!rstn)
      !pready_q |-> prdata_q == psrc_pkg::RDATA_IDLE;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data shown outside the answer cycle");

   // Access to any other word is refused with an error answer
   property p_refuse;
      @(posedge clk) disable iff (!rstn)
      psel && penable && !pready_q && !is_ctrl_word(paddr) |=>
         pready_q && pslverr_q && !wr_hit &&
         prdata_q == psrc_pkg::RDATA_IDLE;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("unmapped access not refused");

   // One wait state: ready follows the first access edge
   property p_ready_wait;
      @(posedge clk) disable iff (!rstn)
      psel && penable && !pready_q |=> pready_q;
   endproperty
   a_ready_wait: assert property (p_ready_wait)
      else $error("ready not given one cycle into the access");

   // A write commits only at the edge where ready is seen
   property p_write_commit;
      @(posedge clk) disable iff (!rstn)
      wr_hit |-> pready_q && !pslverr_q && pwrite;
   endproperty
   a_write_commit: assert property (p_write_commit)
      else $error("write committed outside its ready cycle");

   c_write: cover property (@(posedge clk) disable iff (!rstn) wr_hit);
   c_read: cover property (@(posedge clk) disable iff (!rstn) rd_hit);
   c_phy_on: cover property (@(posedge clk) disable iff (!rstn)
      $rose(phy_unit_reset_q));
   c_err: cover property (@(posedge clk) disable iff (!rstn) pslverr_q);

endmodule // psrc_top

`default_nettype wire

// ==== test/tb.sv ====
// Self-checking bench for the software reset control register
`timescale 1ns/10ps
`default_nettype none
`define CHK(act, exp) \
begin \
   n_compared++; \
   if ((act) !== (exp)) \
   begin \
      error_cnt++; \
      $display("[ERR] %0t got %h want %h", $time, act, exp); \
   end \
end

module tb;
   logic        clk     = 1'b0;
   logic        rstn    = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h00000000;
   logic [31:0] mask    = 32'h00000000;
   logic [31:0] prdata_q;
   logic        pready;
   logic        pslverr;
   logic        phy_unit_reset_q;
   logic        mac_unit_reset_q;
   logic [6:0]  io_port_reset_q;
   logic [31:0] r;
   logic        e;
   int          error_cnt  = 0;
   int          n_compared = 0;
   int          cycles     = 0;

   always #12.5 clk = ~clk;

   psrc_top i_psrc_top (.clk(clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .capability_mask_four(mask), .prdata_q(prdata_q), .pready(pready),
      .pslverr(pslverr), .phy_unit_reset_q(phy_unit_reset_q),
      .mac_unit_reset_q(mac_unit_reset_q),
      .io_port_reset_q(io_port_reset_q));

   ////////////////////////////////////////////////////////////////////////
   // Verdict and hang guard
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Ceiling well above the roughly 130 cycles the tests need
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         error_cnt++;
         end_sim();
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // One APB transfer; answer taken at the rising edge where pready is high
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      r = prdata_q;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // Read back the word, then compare every reset output with it
   task automatic check_word(input logic [31:0] exp);
      xfer(1'b0, psrc_pkg::SRC2_OFFSET, 32'h00000000);
      `CHK(r, exp)
      `CHK(e, 1'b0)
      `CHK(phy_unit_reset_q, exp[30])
      `CHK(mac_unit_reset_q, exp[28])
      `CHK(io_port_reset_q, exp[6:0])
   endtask

   task automatic wr(input logic [31:0] m, input logic [31:0] d);
      mask <= m;
      xfer(1'b1, psrc_pkg::SRC2_OFFSET, d);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Scenarios
   initial
   begin
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      check_word(32'h00000000);
      $display("test reset_value done");
      // Reserved bits must stay zero even with a full mask
      wr(32'hFFFFFFFF, 32'hFFFFFFFF);
      check_word(32'h5000007F);
      $display("test all_ones done");
      // Only bits 28 and 0 enabled: the rest keep their value
      wr(32'h10000001, 32'h00000000);
      check_word(32'h4000007E);
      wr(32'h00000000, 32'hFFFFFFFF);
      check_word(32'h4000007E);
      $display("test mask done");
      // Read-modify-write releases the phy, reserved bits written back
      xfer(1'b0, psrc_pkg::SRC2_OFFSET, 32'h00000000);
      wr(32'hFFFFFFFF, r & ~32'h40000000);
      check_word(32'h0000007E);
      $display("test release done");
      // Each io port alone, back to back
      for (int i = 0; i < 7; i++)
      begin
         wr(32'hFFFFFFFF, 32'h00000001 << i);
         check_word(32'h00000001 << i);
      end
      $display("test ports done");
      // Unmapped word: refused, no effect, reads zero
      xfer(1'b1, 12'h04C, 32'hFFFFFFFF);
      `CHK(e, 1'b1)
      check_word(32'h00000040);
      xfer(1'b0, 12'h04C, 32'h00000000);
      `CHK(e, 1'b1)
      `CHK(r, 32'h00000000)
      $display("test unmapped done");
      // Second reset in mid-run clears the word and the outputs
      wr(32'hFFFFFFFF, 32'h50000000);
      @(posedge clk);
      `CHK(phy_unit_reset_q, 1'b1)
      `CHK(mac_unit_reset_q, 1'b1)
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      check_word(32'h00000000);
      $display("test rereset done");
      end_sim();
   end
endmodule // tb
`default_nettype wire
